// >>> core/sdc_consts.vh
// timing constants and command encodings for the sdram controller
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH
`define SDC_CLK_MHZ        200
`define SDC_INIT_US        100
`define SDC_INIT_CYC       (`SDC_INIT_US * `SDC_CLK_MHZ)
`define SDC_REFI_NS        15600
`define SDC_REFI_CYC       ((`SDC_REFI_NS * `SDC_CLK_MHZ) / 1000 / 2)
`define SDC_SRMIN_US       64
`define SDC_SRMIN_CYC      (`SDC_SRMIN_US * `SDC_CLK_MHZ)
`define SDC_TXSR_NS        70
`define SDC_TXSR_RAW       ((`SDC_TXSR_NS * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_TXSR_CYC       ((`SDC_TXSR_RAW < 2) ? 2 : `SDC_TXSR_RAW)
`define SDC_TRFC_NS        70
`define SDC_TRFC_CYC       ((`SDC_TRFC_NS * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_TRP_NS         20
`define SDC_TRP_CYC        ((`SDC_TRP_NS * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_TMRD_CYC       2
`define SDC_TWR_CYC        2
`define SDC_WAKE_REFS      2
// command = {csN, rasN, casN, weN}
`define SDC_CMD_INHIBIT    4'h8
`define SDC_CMD_NOP        4'h7
`define SDC_CMD_REFRESH    4'h1
`define SDC_CMD_MRS        4'h0
`define SDC_CMD_PRECHARGE  4'h2
`define SDC_CMD_BW         4
`define SDC_CNT_W          16
`define SDC_MODE_DEFAULT   12'h022
`define SDC_A10_ALL        12'h400
`endif

// >>> core/sdc_init_refresh.v
// sdram host: power-up init, periodic refresh, self refresh entry and exit
// Overview of operation
// - wait 100us after power-up, then two auto refreshes before use
// - repeat the two wake-up refreshes whenever the refresh period lapses
// - mode register may be loaded before the two refreshes
// - clock runs during the self refresh exit wait
// - exit-to-active wait is at least two cycles
// - clock frequency never changes during accesses or precharge
// - data rate lowered by dropping clock enable, not the clock
// - only NOP or inhibit issued during the auto refresh period
// - no self refresh re-entry before all rows are refreshed again
// - re-entry allowed if self refresh lasted at least 64us
// - re-entry allowed with two refreshes per 15.6us interval outside
// - refresh kept up while in power-down
// - wait write recovery after last write data before precharge
// - two clocks of write recovery when it exceeds a clock period
// - single-clock recovery allowed only at 100MHz or slower
// - at least 70ns from self refresh exit to active
// - two cycles after mode load before active or refresh
`timescale 1ns/1ps
`include "sdc_consts.vh"
module sdc_init_refresh #(
    parameter INIT_CYC  = `SDC_INIT_CYC,
    parameter SRMIN_CYC = `SDC_SRMIN_CYC,
    parameter REFI_CYC  = `SDC_REFI_CYC
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        selfRefReq,
    input  wire        wrLastData,
    input  wire        pchgReq,
    output reg         sdCke,
    output reg         sdCsN,
    output reg         sdRasN,
    output reg         sdCasN,
    output reg         sdWeN,
    output reg  [11:0] sdAddr,
    output reg  [1:0]  sdBa,
    output reg         ready,
    output reg         inSelfRef,
    output reg         pchgDone
);
    // one-hot states; the default branch recovers from an illegal code
    localparam [8:0] S_POWER = 9'h001;
    localparam [8:0] S_MRS   = 9'h002;
    localparam [8:0] S_MRD   = 9'h004;
    localparam [8:0] S_PALL  = 9'h008;
    localparam [8:0] S_REF   = 9'h010;
    localparam [8:0] S_RFC   = 9'h020;
    localparam [8:0] S_IDLE  = 9'h040;
    localparam [8:0] S_SELF  = 9'h080;
    localparam [8:0] S_XSR   = 9'h100;

    // counter load values; only the low bits are used, cut where loaded
    localparam MRD_LD  = `SDC_TMRD_CYC - 1;
    localparam TRP_LD  = `SDC_TRP_CYC - 1;
    localparam TRFC_LD = `SDC_TRFC_CYC - 1;
    localparam TXSR_LD = `SDC_TXSR_CYC - 1;
    localparam TWR_LD  = `SDC_TWR_CYC;
    localparam WAKE_LD = `SDC_WAKE_REFS;

    reg [8:0]                  state_q;
    reg [`SDC_CNT_W-1:0]       wait_q;
    reg [`SDC_CNT_W-1:0]       refi_q;
    reg [`SDC_CNT_W-1:0]       srTime_q;
    reg [1:0]                  refLeft_q;
    reg                        catchUp_q;
    reg [1:0]                  wr_q;
    reg                        pchgPend_q;
    wire                       refDue;

    // interval timer at zero: a refresh pair is owed
    assign refDue = (refi_q == {`SDC_CNT_W{1'b0}});

    // outside reset one place drives the four command pins so they always change together
    task issue;
        input [3:0] cmd;
        begin
            {sdCsN, sdRasN, sdCasN, sdWeN} <= cmd;
        end
    endtask

    always @(posedge clk) begin
        if (rst) begin
            state_q    <= S_POWER;
            wait_q     <= INIT_CYC[`SDC_CNT_W-1:0];
            refi_q     <= REFI_CYC[`SDC_CNT_W-1:0];
            srTime_q   <= {`SDC_CNT_W{1'b0}};
            refLeft_q  <= 2'h0;
            catchUp_q  <= 1'b0;
            wr_q       <= 2'h0;
            pchgPend_q <= 1'b0;
            sdCke      <= 1'b1;
            {sdCsN, sdRasN, sdCasN, sdWeN} <= `SDC_CMD_INHIBIT;
            sdAddr     <= 12'h000;
            sdBa       <= 2'h0;
            ready      <= 1'b0;
            inSelfRef  <= 1'b0;
            pchgDone   <= 1'b0;
        end else begin
            issue(`SDC_CMD_NOP);
            pchgDone <= 1'b0;

            // refresh interval counts down and holds at zero in every state but self refresh
            if (state_q != S_SELF && !refDue)
                refi_q <= refi_q - 16'h0001;
            if (wait_q != {`SDC_CNT_W{1'b0}})
                wait_q <= wait_q - 16'h0001;

            // write recovery: two clocks at 200 MHz since twr exceeds tck
            if (wrLastData)
                wr_q <= TWR_LD[1:0];
            else if (wr_q != 2'h0)
                wr_q <= wr_q - 2'h1;
            // a request in the cycle the precharge goes out stays pending
            if (pchgReq)
                pchgPend_q <= 1'b1;

            case (state_q)
                S_POWER: begin
                    // mode load first, refreshes after, as allowed
                    if (wait_q == {`SDC_CNT_W{1'b0}})
                        state_q <= S_MRS;
                end

                S_MRS: begin
                    // burst and latency fields fixed by the mode constant
                    issue(`SDC_CMD_MRS);
                    sdAddr  <= `SDC_MODE_DEFAULT;
                    sdBa    <= 2'h0;
                    wait_q  <= MRD_LD[`SDC_CNT_W-1:0];
                    state_q <= S_MRD;
                end

                S_MRD: begin
                    if (wait_q == {`SDC_CNT_W{1'b0}})
                        state_q <= S_PALL;
                end

                S_PALL: begin
                    issue(`SDC_CMD_PRECHARGE);
                    sdAddr    <= `SDC_A10_ALL;
                    wait_q    <= TRP_LD[`SDC_CNT_W-1:0];
                    refLeft_q <= WAKE_LD[1:0];
                    state_q   <= S_REF;
                end

                S_REF: begin
                    // wait_q covers trp after a precharge and trfc inside a pair
                    if (wait_q == {`SDC_CNT_W{1'b0}}) begin
                        issue(`SDC_CMD_REFRESH);
                        refLeft_q <= refLeft_q - 2'h1;
                        refi_q    <= REFI_CYC[`SDC_CNT_W-1:0];
                        wait_q    <= TRFC_LD[`SDC_CNT_W-1:0];
                        state_q   <= S_RFC;
                    end
                end

                S_RFC: begin
                    // only nop goes out while the refresh runs
                    if (wait_q == {`SDC_CNT_W{1'b0}}) begin
                        if (refLeft_q != 2'h0)
                            state_q <= S_REF;
                        else begin
                            state_q <= S_IDLE;
                            ready   <= 1'b1;
                        end
                    end
                end

                S_IDLE: begin
                    if (refDue) begin
                        // a lapsed interval implies the pair, keeping both cases equal
                        refLeft_q <= WAKE_LD[1:0];
                        catchUp_q <= 1'b0;
                        state_q   <= S_REF;
                    end else if (selfRefReq && !catchUp_q && wr_q == 2'h0 &&
                                 wait_q == {`SDC_CNT_W{1'b0}}) begin
                        // entry is a refresh with cke low; trp of a precharge must be met
                        issue(`SDC_CMD_REFRESH);
                        sdCke     <= 1'b0;
                        srTime_q  <= {`SDC_CNT_W{1'b0}};
                        inSelfRef <= 1'b1;
                        ready     <= 1'b0;
                        state_q   <= S_SELF;
                    end else if (pchgPend_q && wr_q == 2'h0 && !wrLastData) begin
                        // trp then runs before any refresh or self refresh entry
                        issue(`SDC_CMD_PRECHARGE);
                        sdAddr     <= `SDC_A10_ALL;
                        wait_q     <= TRP_LD[`SDC_CNT_W-1:0];
                        pchgPend_q <= pchgReq;
                        pchgDone   <= 1'b1;
                    end
                end

                S_SELF: begin
                    // no upper limit here; stays until the request drops
                    if (srTime_q != 16'hffff)
                        srTime_q <= srTime_q + 16'h0001;
                    if (!selfRefReq) begin
                        sdCke   <= 1'b1;
                        wait_q  <= TXSR_LD[`SDC_CNT_W-1:0];
                        state_q <= S_XSR;
                    end
                end

                S_XSR: begin
                    // clock keeps toggling; only cke moved, never the clock rate
                    if (wait_q == {`SDC_CNT_W{1'b0}}) begin
                        // short stay: no new entry until the next periodic pair is out
                        catchUp_q <= (srTime_q < SRMIN_CYC[`SDC_CNT_W-1:0]);
                        refi_q    <= REFI_CYC[`SDC_CNT_W-1:0];
                        inSelfRef <= 1'b0;
                        ready     <= 1'b1;
                        state_q   <= S_IDLE;
                    end
                end

                default: state_q <= S_POWER;
            endcase
        end
    end
endmodule

// >>> verif/sdc_monitor.sv
// assertion checker for the sdram init and refresh controller
`timescale 1ns/1ps
`include "sdc_consts.vh"
module sdc_monitor #(
    parameter INIT_CYC  = 50,
    parameter SRMIN_CYC = 40,
    parameter REFI_CYC  = 100
) (
    input wire        clk,
    input wire        rst,
    input wire        selfRefReq,
    input wire        wrLastData,
    input wire        pchgReq,
    input wire        sdCke,
    input wire        sdCsN,
    input wire        sdRasN,
    input wire        sdCasN,
    input wire        sdWeN,
    input wire [11:0] sdAddr,
    input wire [1:0]  sdBa,
    input wire        ready,
    input wire        inSelfRef,
    input wire        pchgDone
);
    localparam [3:0] CREF = `SDC_CMD_REFRESH;
    wire [3:0]  cmd = {sdCsN, sdRasN, sdCasN, sdWeN};
    wire        idle = (cmd == `SDC_CMD_NOP) || cmd[3];
    reg  [15:0] initCnt;
    reg  [15:0] gapCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // gap restarts outside normal use; a refresh pair may follow self refresh exit late
    always @(posedge clk) begin
        if (rst) initCnt <= 16'h0000;
        else if (!(&initCnt)) initCnt <= initCnt + 16'h0001;
        if (rst || !ready || inSelfRef || cmd == CREF) gapCnt <= 16'h0000;
        else gapCnt <= gapCnt + 16'h0001;
    end
    property p_init; (initCnt < INIT_CYC) |-> idle && !ready; endproperty
    a_init: assert property (p_init) else $error("busy during power-up wait");
    property p_wake; $rose(ready) |-> $past(inSelfRef) || $past(cmd, 14) == CREF; endproperty
    a_wake: assert property (p_wake) else $error("ready without refresh pair");
    property p_rfc; cmd == CREF |=> idle [*8] ##1 idle [*5]; endproperty
    a_rfc: assert property (p_rfc) else $error("command inside refresh period");
    property p_mrd; cmd == `SDC_CMD_MRS |=> idle; endproperty
    a_mrd: assert property (p_mrd) else $error("command right after mode load");
    property p_wr; wrLastData |=> (cmd != `SDC_CMD_PRECHARGE) [*2]; endproperty
    a_wr: assert property (p_wr) else $error("precharge inside write recovery");
    property p_xsr; $rose(sdCke) |-> !ready [*8] ##1 !ready [*5]; endproperty
    a_xsr: assert property (p_xsr) else $error("ready too soon after exit");
    property p_cke; $fell(sdCke) |-> cmd == CREF && !ready; endproperty
    a_cke: assert property (p_cke) else $error("clock enable dropped outside entry");
    property p_gap; gapCnt <= 2 * REFI_CYC; endproperty
    a_gap: assert property (p_gap) else $error("refresh interval overrun");
endmodule
bind sdc_init_refresh sdc_monitor #(.INIT_CYC(INIT_CYC), .SRMIN_CYC(SRMIN_CYC),
    .REFI_CYC(REFI_CYC)) u_mon (.clk(clk), .rst(rst), .selfRefReq(selfRefReq),
    .wrLastData(wrLastData), .pchgReq(pchgReq), .sdCke(sdCke), .sdCsN(sdCsN),
    .sdRasN(sdRasN), .sdCasN(sdCasN), .sdWeN(sdWeN), .sdAddr(sdAddr), .sdBa(sdBa),
    .ready(ready), .inSelfRef(inSelfRef), .pchgDone(pchgDone));

// >>> verif/sdc_mem_model.sv
// behavioural sdram: mode register, refresh count, self refresh state
`timescale 1ns/1ps
`include "sdc_consts.vh"
module sdc_mem_model (
    input  wire        clk,
    input  wire        cke,
    input  wire [3:0]  cmd,
    input  wire [11:0] addr,
    output reg  [7:0]  refCnt,
    output reg         inSr,
    output reg  [11:0] modeReg
);
    initial refCnt = 8'h00;
    initial inSr = 1'b0;
    initial modeReg = 12'h000;
    // no column decode: the whole address, bits 8, 9 and 11 included, goes into modeReg on a mode load
    always @(posedge clk) begin
        if (cke) inSr <= 1'b0;
        else if (cmd == `SDC_CMD_REFRESH) inSr <= 1'b1;
        if (cke && cmd == `SDC_CMD_REFRESH) refCnt <= refCnt + 8'h01;
        if (cmd == `SDC_CMD_MRS) modeReg <= addr;
    end
endmodule

// >>> verif/tb.sv
// self-checking bench for the sdram init and refresh controller
`timescale 1ns/1ps
`include "sdc_consts.vh"
module tb;
    reg         clk, rst, selfRefReq, wrLastData, pchgReq;
    wire        sdCke, sdCsN, sdRasN, sdCasN, sdWeN, ready, inSelfRef, pchgDone, inSr;
    wire [11:0] sdAddr, modeReg;
    wire [1:0]  sdBa;
    wire [7:0]  refCnt;
    reg  [7:0]  lf, r0;
    integer     n_fail, n_checks, cyc, i, d;
    sdc_init_refresh #(.INIT_CYC(50), .SRMIN_CYC(40), .REFI_CYC(100)) u_dut (.clk(clk),
        .rst(rst), .selfRefReq(selfRefReq), .wrLastData(wrLastData), .pchgReq(pchgReq),
        .sdCke(sdCke), .sdCsN(sdCsN), .sdRasN(sdRasN), .sdCasN(sdCasN), .sdWeN(sdWeN),
        .sdAddr(sdAddr), .sdBa(sdBa), .ready(ready), .inSelfRef(inSelfRef),
        .pchgDone(pchgDone));
    sdc_mem_model u_mem (.clk(clk), .cke(sdCke), .cmd({sdCsN, sdRasN, sdCasN, sdWeN}),
        .addr(sdAddr), .refCnt(refCnt), .inSr(inSr), .modeReg(modeReg));
    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task check(input string name, input [31:0] seen, input [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // 0 ready, 1 entered, 2 precharged, 3 left self refresh
    task waitOn(input integer sel, output integer n);
        n = 0;
        while (!(sel == 0 ? ready === 1'b1 : sel == 1 ? inSelfRef === 1'b1 :
                 sel == 2 ? pchgDone === 1'b1 : inSelfRef === 1'b0) && n < 2000) begin
            @(negedge clk);
            n = n + 1;
        end
        if (n >= 2000) n_fail = n_fail + 1;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial cyc = 0;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end
    initial begin
        {rst, selfRefReq, wrLastData, pchgReq} = 4'h8;
        n_fail = 0;
        n_checks = 0;
        lf = 8'h25;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        waitOn(0, d);
        check("initWait", d > 50, 1);
        check("wakeRefs", refCnt, 2);
        check("modeReg", modeReg, `SDC_MODE_DEFAULT);
        check("bankSel", sdBa, 2'h0);
        for (i = 0; i < 4; i = i + 1) begin
            lf = lfsr(lf);
            repeat (lf[3:0]) @(negedge clk);
            {wrLastData, pchgReq} = 2'b11;
            @(negedge clk);
            {wrLastData, pchgReq} = 2'b00;
            waitOn(2, d);
            check("wrRecovery", d >= 3, 1);
            check("pchgAll", sdAddr, `SDC_A10_ALL);
        end
        for (i = 0; i < 2; i = i + 1) begin
            lf = lfsr(lf);
            selfRefReq = 1'b1;
            waitOn(1, d);
            check("ckeLow", sdCke, 0);
            @(negedge clk);
            check("srModel", inSr, 1);
            repeat (i ? 60 + lf[4:0] : 5 + lf[4:0]) @(negedge clk);
            selfRefReq = 1'b0;
            waitOn(3, d);
            check("exitWait", d >= 14, 1);
            check("readyBack", ready, 1);
            r0 = refCnt;
            selfRefReq = 1'b1;
            waitOn(1, d);
            if (i) check("quickReEnter", d <= 2, 1);
            else check("reEnter", (refCnt - r0) >= 8'd2, 1);
            selfRefReq = 1'b0;
            waitOn(3, d);
        end
        r0 = refCnt;
        repeat (450) @(negedge clk);
        check("periodic", (refCnt - r0) >= 8'd4, 1);
        wrap_up;
    end
endmodule
